// *** rtl/via_pkg.sv ***
// via_pkg: constants and carrier types of the vectored interrupt arbiter
package via_pkg;

   // ************************************************************
   // vectors, levels and reset values
   // ************************************************************
   localparam logic [15:0] VIA_VEC_NMI      = 16'h0004;  // non-maskable watchdog vector
   localparam logic [15:0] VIA_VEC_STEP     = 16'h0002;  // two bytes per table entry
   localparam logic [3:0]  VIA_LVL_WDT      = 4'h0;      // watchdog as interval timer
   localparam logic [3:0]  VIA_LVL_PIN0     = 4'h1;      // first external pin
   localparam logic [3:0]  VIA_LVL_RX       = 4'h5;      // serial receive complete
   localparam logic [3:0]  VIA_LVL_TX       = 4'h6;      // serial transmit complete
   localparam logic [3:0]  VIA_LVL_WATCH    = 4'h7;      // watch timer
   localparam logic [3:0]  VIA_LVL_WATCHIV  = 4'h8;      // watch interval timer
   localparam logic [3:0]  VIA_LVL_TMR8A    = 4'h9;      // first 8-bit timer match
   localparam logic [3:0]  VIA_LVL_TMR8B    = 4'hA;      // second 8-bit timer match
   localparam logic [3:0]  VIA_LVL_TMR8C    = 4'hB;      // third 8-bit timer match
   localparam logic [3:0]  VIA_LVL_TMR16    = 4'hC;      // 16-bit timer match
   localparam logic [3:0]  VIA_LVL_BUS      = 4'hD;      // serial bus controller transfer
   localparam logic [3:0]  VIA_LVL_BUSTO    = 4'hE;      // serial bus controller timeout
   localparam logic [3:0]  VIA_LVL_ADC      = 4'hF;      // conversion complete, lowest
   localparam logic [15:0] VIA_FLAG_RESET   = 16'h0000;  // request flags after reset
   localparam logic [15:0] VIA_MASK_RESET   = 16'hFFFF;  // all sources masked after reset
   localparam logic [15:0] VIA_BUS_SRC_BITS = 16'h6000;  // levels 13 and 14

   // ************************************************************
   // edge selector encodings
   // ************************************************************
   localparam logic [1:0]  VIA_EDGE_FALL    = 2'h0;      // falling edge
   localparam logic [1:0]  VIA_EDGE_RISE    = 2'h1;      // rising edge
   localparam logic [1:0]  VIA_EDGE_BOTH    = 2'h3;      // both edges, 2'h2 not allowed

   // ************************************************************
   // carrier types
   // ************************************************************
   // one-cycle event pulses from the internal peripherals
   typedef struct packed {
      logic watchdog_overflow_irq;     // watchdog overflow
      logic serial_rx_done_irq;        // asynchronous receive complete
      logic sync_serial_rx_done_irq;   // three-wire receive complete
      logic serial_tx_done_irq;        // asynchronous transmit complete
      logic watch_timer_irq;           // watch timer
      logic watch_interval_irq;        // watch interval timer
      logic timer8_a_match_irq;        // first 8-bit timer match
      logic timer8_b_match_irq;        // second 8-bit timer match
      logic timer8_c_match_irq;        // third 8-bit timer match
      logic timer16_match_irq;         // 16-bit timer match
      logic bus_ctrl_irq;              // serial bus controller transfer
      logic bus_timeout_irq;           // serial bus controller timeout
      logic adc_done_irq;              // conversion complete
   } via_events_t;

   // request presented to the cpu core
   typedef struct packed {
      logic        req;                // a request is presented
      logic        isNmi;              // presented request is the non-maskable one
      logic [3:0]  level;              // priority level of a maskable request
      logic [15:0] vector;             // vector table address
   } via_present_t;

   // whole state of the arbiter
   typedef struct packed {
      logic [3:0]   pinSync1;          // first synchroniser stage
      logic [3:0]   pinSync2;          // second synchroniser stage
      logic [3:0]   pinPrev;           // previous synchronised level
      logic [15:0]  flags;             // maskable request flags by level
      logic         nmiFlag;           // non-maskable request flag
      logic [15:0]  mask;              // mask bits, 1 disables
      logic         standbyRelease;    // wake request to the core
      via_present_t present;           // presented request
   } via_state_t;

endpackage

// *** rtl/via_vectored_interrupt_arbiter.sv ***
// via_vectored_interrupt_arbiter: fixed-priority interrupt arbiter and vector generator
// Function
// RL1 - Non-maskable request always accepted, ranked highest
// RL2 - Watchdog overflow in mode 1 vectors 0004H
// RL3 - Any request raises standby release; code raises it only for the non-maskable or an unmasked maskable request
// RL4 - Maskable requests masked, fixed priority among them
// RL5 - Levels 0 highest through 15 lowest
// RL6 - Interval-mode watchdog is maskable level 0
// RL7 - Four pin edges, levels 1-4, vectors 0006H-000CH
// RL8 - Both serial receive events share level 5
// RL9 - Serial transmit complete at level 6
// RL10 - First two 8-bit timers at levels 9, 10
// RL11 - Third 8-bit timer 11, 16-bit timer 12
// RL12 - Conversion complete lowest, level 15, 0022H
// RL13 - Bus controller variant adds two internal sources
// RL14 - Bus transfer level 13, timeout level 14
// RL15 - Flags set by source or software, cleared
// RL16 - Mask 0 enables, 1 disables, reset ones
// RL17 - Edge select falling, rising, both; 10 none
// RL18 - Global enable gates all maskable requests
// RL19 - Present only best unmasked pending maskable request
`timescale 1ns/1ps

module via_vectored_interrupt_arbiter
   import via_pkg::*;
#(
   parameter bit HAS_BUS_CTRL = 1'b1                // variant with serial bus controller
) (
   input  wire logic         mclk,                  // cpu clock, 25 MHz
   input  wire logic         rst,                   // asynchronous reset, active high
   input  wire via_events_t  events,                // internal event pulses
   input  wire logic [3:0]   extPins,               // external interrupt pins, asynchronous
   input  wire logic [7:0]   edgeSel,               // two bits per pin, pin 0 lowest
   input  wire logic         wdtMode1,              // watchdog in mode 1, else interval timer
   input  wire logic         global_irq_enable,     // core's global maskable enable
   input  wire logic         mask_bank_a_wr,        // write pulse for mask levels 0-7
   input  wire logic         mask_bank_b_wr,        // write pulse for mask levels 8-15
   input  wire logic [7:0]   maskWrData,            // data for mask bank write
   input  wire logic [15:0]  flagSetSw,             // software set pulses per level
   input  wire logic [15:0]  flagClrSw,             // software clear pulses per level
   input  wire logic         nmiClrSw,              // software clear of non-maskable flag
   input  wire logic         irqAck,                // core acknowledges presented request
   output via_present_t      irqPresent,            // presented request and its vector
   output logic              standbyRelease,        // wake a halted or stopped core
   output logic [15:0]       reqFlags,              // request flag readback
   output logic              nmiPending,            // non-maskable flag readback
   output logic [15:0]       maskFlags              // mask readback
);

   // ************************************************************
   // helper functions
   // ************************************************************

   // index of the lowest set bit, which is the highest priority
   function automatic logic [3:0] pickLevel(input logic [15:0] req);
      logic [3:0] lvl;
      lvl = 4'hF;
      for (int i = 15; i >= 0; i--) begin
         if (req[i]) begin
            lvl = 4'(i);
         end
      end
      return lvl;
   endfunction

   // vector of a maskable level; level 0 shares the watchdog entry
   function automatic logic [15:0] levelVector(input logic [3:0] lvl);
      logic [15:0] vec;
      vec = VIA_VEC_NMI + 16'(lvl) * VIA_VEC_STEP;   // see RL7, RL12, RL14
      return vec;
   endfunction

   // edge detection for one pin under its two-bit selector
   function automatic logic pinEdge(input logic prev, input logic cur, input logic [1:0] sel);
      logic hit;
      hit = 1'b0;
      case (sel)
         VIA_EDGE_FALL: hit = prev & ~cur;           // see RL17
         VIA_EDGE_RISE: hit = ~prev & cur;           // see RL17
         VIA_EDGE_BOTH: hit = prev ^ cur;            // see RL17
         default:       hit = 1'b0;                  // prohibited value detects nothing
      endcase
      return hit;
   endfunction

   // ************************************************************
   // state
   // ************************************************************
   via_state_t state_q;
   via_state_t state_d;

   logic [15:0] srcHit;       // hardware set pulses by level
   logic        nmiHit;       // hardware set of the non-maskable flag
   logic [15:0] ackClr;       // clear from acknowledgement by level
   logic        ackNmi;       // acknowledgement of the non-maskable request
   logic [15:0] avail;        // levels implemented in this variant
   logic [15:0] flagsNew;     // request flags after this cycle
   logic [15:0] maskNew;      // mask after this cycle
   logic        nmiNew;       // non-maskable flag after this cycle
   logic [15:0] eligible;     // pending and unmasked
   logic [3:0]  winLevel;     // winning maskable level

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      state_d = state_q;

      // pins pass two flip-flops before the edge detector looks at them
      state_d.pinSync1 = extPins;
      state_d.pinSync2 = state_q.pinSync1;
      state_d.pinPrev  = state_q.pinSync2;

      // levels 13 and 14 exist only with the serial bus controller
      avail = HAS_BUS_CTRL ? 16'hFFFF : ~VIA_BUS_SRC_BITS;   // see RL13

      // map source events onto levels
      srcHit = 16'h0000;
      srcHit[VIA_LVL_WDT]     = events.watchdog_overflow_irq & ~wdtMode1;   // see RL6
      for (int p = 0; p < 4; p++) begin
         srcHit[VIA_LVL_PIN0 + 4'(p)] = pinEdge(state_q.pinPrev[p], state_q.pinSync2[p],
                                                edgeSel[2*p +: 2]);          // see RL7
      end
      srcHit[VIA_LVL_RX]      = events.serial_rx_done_irq
                              | events.sync_serial_rx_done_irq;            // see RL8
      srcHit[VIA_LVL_TX]      = events.serial_tx_done_irq;                 // see RL9
      srcHit[VIA_LVL_WATCH]   = events.watch_timer_irq;
      srcHit[VIA_LVL_WATCHIV] = events.watch_interval_irq;
      srcHit[VIA_LVL_TMR8A]   = events.timer8_a_match_irq;                 // see RL10
      srcHit[VIA_LVL_TMR8B]   = events.timer8_b_match_irq;                 // see RL10
      srcHit[VIA_LVL_TMR8C]   = events.timer8_c_match_irq;                 // see RL11
      srcHit[VIA_LVL_TMR16]   = events.timer16_match_irq;                  // see RL11
      srcHit[VIA_LVL_BUS]     = events.bus_ctrl_irq;                       // see RL14
      srcHit[VIA_LVL_BUSTO]   = events.bus_timeout_irq;                    // see RL14
      srcHit[VIA_LVL_ADC]     = events.adc_done_irq;                       // see RL12
      nmiHit = events.watchdog_overflow_irq & wdtMode1;                    // see RL2

      // acknowledgement clears the source that is being presented
      ackNmi = irqAck & state_q.present.req & state_q.present.isNmi;
      ackClr = 16'h0000;
      if (irqAck && state_q.present.req && !state_q.present.isNmi) begin
         ackClr[state_q.present.level] = 1'b1;                             // see RL15
      end

      // set wins over any clear arriving in the same cycle
      flagsNew = ((state_q.flags & ~flagClrSw & ~ackClr) | srcHit | flagSetSw) & avail; // see RL15
      nmiNew   = (state_q.nmiFlag & ~nmiClrSw & ~ackNmi) | nmiHit;                      // see RL1
      state_d.flags   = flagsNew;
      state_d.nmiFlag = nmiNew;

      // mask bank writes; absent levels stay masked
      maskNew = state_q.mask;
      if (mask_bank_a_wr) begin
         maskNew[7:0] = maskWrData;                                        // see RL16
      end
      if (mask_bank_b_wr) begin
         maskNew[15:8] = maskWrData;                                       // see RL16
      end
      maskNew = maskNew | ~avail;
      state_d.mask = maskNew;

      // mask 0 lets a pending flag through; lowest level wins
      eligible = flagsNew & ~maskNew;                                      // see RL4, RL16
      winLevel = pickLevel(eligible);                                      // see RL5

      // wake on any request the core could take, regardless of global enable
      state_d.standbyRelease = nmiNew | (|eligible);                       // see RL3

      // non-maskable first, bypassing arbitration and the global enable
      if (nmiNew) begin
         state_d.present.req    = 1'b1;                                    // see RL1
         state_d.present.isNmi  = 1'b1;
         state_d.present.level  = 4'h0;
         state_d.present.vector = VIA_VEC_NMI;                             // see RL2
      end else if (global_irq_enable && (|eligible)) begin
         state_d.present.req    = 1'b1;                                    // see RL18, RL19
         state_d.present.isNmi  = 1'b0;
         state_d.present.level  = winLevel;                                // see RL19
         state_d.present.vector = levelVector(winLevel);
      end else begin
         state_d.present.req    = 1'b0;                                    // see RL18
         state_d.present.isNmi  = 1'b0;
         state_d.present.level  = 4'h0;
         state_d.present.vector = 16'h0000;
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q.pinSync1       <= 4'h0;
         state_q.pinSync2       <= 4'h0;
         state_q.pinPrev        <= 4'h0;
         state_q.flags          <= VIA_FLAG_RESET;                         // see RL15
         state_q.nmiFlag        <= 1'b0;
         state_q.mask           <= VIA_MASK_RESET;                         // see RL16
         state_q.standbyRelease <= 1'b0;
         state_q.present        <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   // ************************************************************
   // outputs, all straight from state flip-flops
   // ************************************************************
   assign irqPresent     = state_q.present;
   assign standbyRelease = state_q.standbyRelease;
   assign reqFlags       = state_q.flags;
   assign nmiPending     = state_q.nmiFlag;
   assign maskFlags      = state_q.mask;

endmodule

// *** testbench/via_cpu_model.sv ***
// via_cpu_model: cpu core that acknowledges presented requests
`timescale 1ns/1ps
module via_cpu_model
   import via_pkg::*;
(
   input  wire logic         mclk,       // cpu clock
   input  wire logic         rst,        // reset, active high
   input  wire via_present_t irqPresent, // request shown by the arbiter
   input  wire logic         ackEn,      // core accepts interrupts
   input  wire logic [3:0]   ackDelay,   // cycles waited before acking
   output logic              irqAck,     // acknowledge pulse
   output logic [15:0]       ackVec,     // vector shown when ack was taken
   output int                ackCount    // acks taken
);
   logic [3:0] waitCnt_q;
   // wait, pulse ack one cycle, note the vector it was taken with
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irqAck    <= 1'b0;
         waitCnt_q <= 4'h0;
         ackVec    <= 16'h0000;
         ackCount  <= 0;
      end else if (irqAck) begin
         irqAck   <= 1'b0;
         ackVec   <= irqPresent.vector;
         ackCount <= ackCount + 1;
      end else if (ackEn && irqPresent.req) begin
         irqAck    <= (waitCnt_q == ackDelay);
         waitCnt_q <= (waitCnt_q == ackDelay) ? 4'h0 : waitCnt_q + 4'h1;
      end
   end
endmodule

// *** testbench/via_properties.sv ***
// via_properties: port-level checks of the arbiter
`timescale 1ns/1ps
module via_properties
   import via_pkg::*;
#(
   parameter bit HAS_BUS_CTRL = 1'b1         // variant with bus controller
) (
   input wire logic         mclk,              // cpu clock
   input wire logic         rst,               // reset, active high
   input wire via_events_t  events,            // event pulses
   input wire logic         wdtMode1,          // watchdog mode 1
   input wire logic         global_irq_enable, // maskable enable
   input wire logic         mask_bank_a_wr,    // low mask write
   input wire logic         mask_bank_b_wr,    // high mask write
   input wire logic [7:0]   maskWrData,        // mask write data
   input wire logic [15:0]  flagSetSw,         // software set
   input wire logic         irqAck,            // core acknowledge
   input wire via_present_t irqPresent,        // presented request
   input wire logic         standbyRelease,    // wake signal
   input wire logic [15:0]  reqFlags,          // request flags
   input wire logic         nmiPending,        // nmi flag
   input wire logic [15:0]  maskFlags          // mask bits
);
   logic [15:0] okLvl;
   logic [15:0] live;
   logic [15:0] above;
   logic [15:0] vecExp;
   // pending unmasked requests, those ranked above the shown one, expected vector
   assign okLvl  = HAS_BUS_CTRL ? 16'hFFFF : ~VIA_BUS_SRC_BITS;
   assign live   = reqFlags & ~maskFlags;
   assign above  = live & ((16'h0001 << irqPresent.level) - 16'h0001);
   assign vecExp = (irqPresent.level == 4'h0) ? VIA_VEC_NMI :
                   VIA_VEC_NMI + VIA_VEC_STEP * {12'h000, irqPresent.level};
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   nmi_top_a: assert property (nmiPending |-> irqPresent.req && irqPresent.isNmi
      && irqPresent.vector == VIA_VEC_NMI) else $error("nmi not presented first");
   wake_level_a: assert property (standbyRelease == (nmiPending || live != 16'h0000))
      else $error("standby release wrong");
   best_win_a: assert property (irqPresent.req && !irqPresent.isNmi |->
      live[irqPresent.level] && above == 16'h0000) else $error("wrong winner");
   ie_gate_a: assert property (irqPresent.req && !irqPresent.isNmi |->
      $past(global_irq_enable)) else $error("maskable shown while disabled");
   vec_map_a: assert property (irqPresent.req && !irqPresent.isNmi |->
      irqPresent.vector == vecExp) else $error("vector wrong");
   mask_lo_a: assert property (mask_bank_a_wr |=> maskFlags[7:0] == $past(maskWrData))
      else $error("low mask not written");
   mask_hi_a: assert property (mask_bank_b_wr |=>
      maskFlags[15:8] == ($past(maskWrData) | ~okLvl[15:8])) else $error("high mask wrong");
   sw_set_a: assert property (flagSetSw != 16'h0000 |=>
      (reqFlags & $past(flagSetSw & okLvl)) == $past(flagSetSw & okLvl)) else $error("no set");
   nmi_ack_a: assert property (irqAck && irqPresent.isNmi &&
      !(events.watchdog_overflow_irq && wdtMode1) |=> !nmiPending) else $error("nmi kept");
   reset_val_a: assert property (disable iff (1'b0) rst |-> maskFlags == VIA_MASK_RESET
      && reqFlags == VIA_FLAG_RESET && !standbyRelease) else $error("reset values wrong");
endmodule
bind via_vectored_interrupt_arbiter via_properties #(.HAS_BUS_CTRL(HAS_BUS_CTRL)) chk_u (
   .mclk(mclk), .rst(rst), .events(events), .wdtMode1(wdtMode1),
   .global_irq_enable(global_irq_enable), .mask_bank_a_wr(mask_bank_a_wr),
   .mask_bank_b_wr(mask_bank_b_wr), .maskWrData(maskWrData), .flagSetSw(flagSetSw),
   .irqAck(irqAck), .irqPresent(irqPresent), .standbyRelease(standbyRelease),
   .reqFlags(reqFlags), .nmiPending(nmiPending), .maskFlags(maskFlags));

// *** testbench/via_vectored_interrupt_arbiter_tb.sv ***
// via_vectored_interrupt_arbiter_tb: directed tests of the arbiter
`timescale 1ns/1ps
module via_vectored_interrupt_arbiter_tb
   import via_pkg::*;
;
   logic mclk, rst, wdtMode1, ie, mA, mB, irqAck, sbr, nmiP, ackEn;
   logic [3:0] extPins, ackDelay;
   logic [7:0] edgeSel, mD;
   logic [15:0] fSet, fClr, reqFlags, maskFlags, ackVec, rf0, mf0;
   via_events_t events;
   via_present_t pres;
   int n_fail, n_checks, ackCount, i;
   logic [3:0] lvlOf [13] = '{4'h0, 4'h5, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
                              4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
   via_vectored_interrupt_arbiter dut_u (.mclk(mclk), .rst(rst), .events(events),
      .extPins(extPins), .edgeSel(edgeSel), .wdtMode1(wdtMode1), .global_irq_enable(ie),
      .mask_bank_a_wr(mA), .mask_bank_b_wr(mB), .maskWrData(mD), .flagSetSw(fSet),
      .flagClrSw(fClr), .nmiClrSw(1'b0), .irqAck(irqAck), .irqPresent(pres),
      .standbyRelease(sbr), .reqFlags(reqFlags), .nmiPending(nmiP), .maskFlags(maskFlags));
   // variant without the bus controller, fed the same stimulus, never acknowledged
   via_vectored_interrupt_arbiter #(.HAS_BUS_CTRL(1'b0)) dut0_u (.mclk(mclk), .rst(rst),
      .events(events), .extPins(extPins), .edgeSel(edgeSel), .wdtMode1(wdtMode1),
      .global_irq_enable(ie), .mask_bank_a_wr(mA), .mask_bank_b_wr(mB), .maskWrData(mD),
      .flagSetSw(fSet), .flagClrSw(fClr), .nmiClrSw(1'b0), .irqAck(1'b0), .irqPresent(),
      .standbyRelease(), .reqFlags(rf0), .nmiPending(), .maskFlags(mf0));
   via_cpu_model cpu_u (.mclk(mclk), .rst(rst), .irqPresent(pres), .ackEn(ackEn),
      .ackDelay(ackDelay), .irqAck(irqAck), .ackVec(ackVec), .ackCount(ackCount));
   // clock
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // one-cycle pulses on events and software set/clear
   task automatic evt(input via_events_t e, input logic [15:0] s, input logic [15:0] c);
      @(posedge mclk);
      events <= e;
      fSet <= s;
      fClr <= c;
      @(posedge mclk);
      events <= '0;
      fSet <= 16'h0000;
      fClr <= 16'h0000;
      #1;
   endtask
   task automatic maskWr(input logic a, input logic b, input logic [7:0] d);
      @(posedge mclk);
      mA <= a;
      mB <= b;
      mD <= d;
      @(posedge mclk);
      mA <= 1'b0;
      mB <= 1'b0;
      #1;
   endtask
   task automatic waitAck(input int n0);
      for (int k = 0; k < 60 && ackCount == n0; k++) begin
         @(posedge mclk);
         #1;
      end
      if (ackCount == n0) begin
         n_fail++;
         finish_test();
      end
   endtask
   function automatic logic [15:0] vecOf(input logic [3:0] l);
      return (l == 4'h0) ? 16'h0004 : 16'h0004 + {11'h000, l, 1'b0};
   endfunction
   // main sequence
   initial begin
      rst = 1'b1; events = '0; extPins = 4'h0; edgeSel = 8'hB4; wdtMode1 = 1'b0; ie = 1'b1;
      mA = 1'b0; mB = 1'b0; mD = 8'h00; fSet = 16'h0000; fClr = 16'h0000;
      ackEn = 1'b0; ackDelay = 4'h0; n_fail = 0; n_checks = 0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      #1;
      check(maskFlags, 16'hFFFF);
      check(reqFlags, 16'h0000);
      $display("test reset done");
      maskWr(1'b1, 1'b1, 8'h00);
      check(maskFlags, 16'h0000);
      check(mf0, 16'h6000);
      for (i = 0; i < 13; i++) begin
         evt(via_events_t'(13'h1000 >> i), 16'h0000, 16'h0000);
         check(reqFlags, 16'h0001 << lvlOf[i]);
         check(rf0, (16'h0001 << lvlOf[i]) & 16'h9FFF);
         check(pres.vector, vecOf(lvlOf[i]));
         check({12'h000, pres.level}, {12'h000, lvlOf[i]});
         evt('0, 16'h0000, 16'hFFFF);
      end
      $display("test sources done");
      evt(via_events_t'(13'h1FFF), 16'h001E, 16'h0000);
      @(posedge mclk);
      ackEn <= 1'b1;
      for (i = 0; i < 16; i++) begin
         waitAck(ackCount);
         check(ackVec, vecOf(i[3:0]));
      end
      check({15'h0000, sbr}, 16'h0000);
      ackEn <= 1'b0;
      $display("test priority done");
      maskWr(1'b1, 1'b0, 8'h20);
      evt(via_events_t'(13'h0800), 16'h0000, 16'h0000);
      check({14'h0000, sbr, pres.req}, 16'h0000);
      maskWr(1'b1, 1'b0, 8'h00);
      check({14'h0000, sbr, pres.req}, 16'h0003);
      @(posedge mclk);
      ie <= 1'b0;
      @(posedge mclk);
      @(posedge mclk);
      #1;
      check({14'h0000, sbr, pres.req}, 16'h0002);
      evt('0, 16'h0000, 16'hFFFF);
      $display("test mask done");
      maskWr(1'b1, 1'b1, 8'hFF);
      @(posedge mclk);
      wdtMode1 <= 1'b1;
      evt(via_events_t'(13'h1000), 16'h0002, 16'h0000);
      check({13'h0000, nmiP, pres.isNmi, pres.req}, 16'h0007);
      check(pres.vector, 16'h0004);
      check(reqFlags, 16'h0002);
      ackDelay <= 4'h3;
      ackEn <= 1'b1;
      waitAck(ackCount);
      check({15'h0000, nmiP}, 16'h0000);
      check(ackVec, 16'h0004);
      ackEn <= 1'b0;
      evt('0, 16'h0000, 16'hFFFF);
      $display("test nmi done");
      extPins <= 4'hF;
      repeat (4) @(posedge mclk);
      #1;
      check(reqFlags, 16'h000C);
      evt('0, 16'h0000, 16'hFFFF);
      extPins <= 4'h0;
      repeat (4) @(posedge mclk);
      #1;
      check(reqFlags, 16'h000A);
      $display("test pins done");
      finish_test();
   end
endmodule
